// [ifpm_host_model.sv]
// Host model: AHB-Lite master standing in for the command interpreter.
// Assumes one slave whose hreadyout is fed back as the bus hready.
`timescale 1ns/1ps
`default_nettype none
module ifpm_host_model (
    input wire logic clk_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic [1:0] htrans_o,
    output logic [31:0] haddr_o,
    output logic hwrite_o,
    output logic [31:0] hwdata_o
);
    // Bus idle from time zero
    initial begin
        htrans_o = 2'h0;
        haddr_o = 32'h0;
        hwrite_o = 1'b0;
        hwdata_o = 32'h0;
    end
    ////////////////////////////////////////////////////////////
    // No cycle count assumed; only the bench timeout ends a hang
    task automatic wait_ready();
        @(posedge clk_i);
        while (hready_i !== 1'b1) @(posedge clk_i);
    endtask : wait_ready
    // Single word transfer, entered right after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
            output logic [31:0] rd);
        htrans_o <= 2'h2;
        haddr_o <= {24'h0, adr};
        hwrite_o <= wr;
        wait_ready();
        htrans_o <= 2'h0;
        // Reads drive inverted data so a stale copy cannot pass
        hwdata_o <= wr ? wd : ~hwdata_o;
        wait_ready();
        rd = hrdata_i;
    endtask : xfer
    // Routing always written before its polarity setting
    task automatic set_route(input int f, input logic [31:0] port, input logic inv);
        logic [31:0] rd;
        xfer(1'b1, ifpm_pkg::OFS_ROUTE[f], port, rd);
        xfer(1'b1, ifpm_pkg::OFS_INV[f], {31'h0, inv}, rd);
    endtask : set_route
endmodule : ifpm_host_model
`default_nettype wire

// [ifpm_pkg.sv]
// Constants, register map and types for the input function port mapper.
// Assumes a 32-bit AHB-Lite bus with word-aligned registers.
package ifpm_pkg;

    // Number of routable functions and general input ports
    localparam int NUM_FUNC = 3;
    localparam int NUM_PORTS = 8;

    // Function indices
    localparam int FUNC_HALT = 0;
    localparam int FUNC_HOLD = 1;
    localparam int FUNC_RESUME = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_COMMAND = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ROUTE [NUM_FUNC] = '{8'h10, 8'h14, 8'h18};
    localparam logic [7:0] OFS_INV [NUM_FUNC] = '{8'h20, 8'h24, 8'h28};

    // Command register bits (write only, self clearing)
    localparam int CMD_CLEAR_ALL = 0;
    localparam int CMD_RUN = 1;
    localparam int CMD_ALARM_CLEAR = 2;
    localparam int CMD_REJECT_CLR = 3;

    // Status register fields
    localparam int STS_LEVEL_LSB = 0;
    localparam int STS_ASSIGNED_LSB = 4;
    localparam int STS_REJECT = 8;

    // Highest legal routing value
    localparam logic [31:0] ROUTE_MAX = 32'h0000_0007;

    // AHB encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int HTRANS_ACTIVE_BIT = 1;

    ////////////////////////////////////////////////////////////////////////////
    // One routing entry
    typedef struct packed {
        logic assigned;
        logic [2:0] port;
        logic invert;
    } ifpm_route_t;

    // Factory default: not routed, port 0, normal polarity
    localparam ifpm_route_t ROUTE_DEFAULT = '{assigned: 1'b0, port: 3'h0, invert: 1'b0};

endpackage : ifpm_pkg

// [ifpm_selector.sv]
// Per-function input selector with polarity inversion.
// Assumes the general inputs are synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module ifpm_selector (
    input wire logic [7:0] gp_in_i,
    input wire ifpm_pkg::ifpm_route_t route_i,
    output logic level_o
);

    // Unrouted function reads inactive regardless of the pins
    always_comb begin
        level_o = route_i.assigned & (gp_in_i[route_i.port] ^ route_i.invert); // R4 R5
    end

endmodule : ifpm_selector
`default_nettype wire

// [ifpm_top.sv]
// Input function port mapper: routes halt, hold and resume functions to
// any of eight general input ports, with AHB-Lite register access.
// Assumes one 10 MHz core clock and a single AHB-Lite master.
//
// Summary of operation
// (R1) Clear-all command cancels every function-to-port routing.
// (R2) Halt routing takes 0..7 and routes halt from that port.
// (R3) Hold routing takes 0..7 and routes hold from that port.
// (R4) Routing value N connects the function to general input N.
// (R5) Invert bit set to 1 inverts the routed input level.
// (R6) Routings live only in volatile flops and revert to defaults.
// (R7) Defaults restored at reset and at program start, command or input.
// (R8) Defaults restored at alarm clear, command or input.
// (R9) Software writes halt routing before halt invert.
// (R10) Software writes hold routing before hold invert.
// (R11) Resume function is a third routable function, 0..7.
// (R12) Routings are write-only; values above seven are rejected unchanged.
`timescale 1ns/1ps
`default_nettype none
module ifpm_top (
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    // AHB-Lite slave
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // Pins
    input wire logic [7:0] GP_IN_I,
    input wire logic START_I,
    input wire logic ALARM_CLR_I,
    output logic HALT_O,
    output logic HOLD_O,
    output logic RESUME_O
);

    localparam int NF = ifpm_pkg::NUM_FUNC;

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic wr_pend_q, wr_pend_d;
    logic [7:0] addr_q, addr_d;
    logic word_q, word_d;
    logic [31:0] rdata_q, rdata_d;
    ifpm_pkg::ifpm_route_t route_q [NF];
    ifpm_pkg::ifpm_route_t route_d [NF];
    logic reject_q, reject_d;
    logic start_q, alarm_q;
    logic [NF-1:0] func_q, func_d;
    logic [NF-1:0] sel_level;
    logic addr_phase;
    logic wr_ok;
    logic cmd_wr;
    logic reinit;
    logic [NF-1:0] route_wr;
    logic [NF-1:0] inv_wr;
    logic bad_value;

    ////////////////////////////////////////////////////////////////////////////
    // Bus address phase capture; zero wait states, so hready is always high
    always_comb begin
        addr_phase = HSEL_I & HREADY_I & HTRANS_I[ifpm_pkg::HTRANS_ACTIVE_BIT];
        wr_pend_d = addr_phase & HWRITE_I;
        addr_d = addr_phase ? HADDR_I[7:0] : addr_q;
        word_d = addr_phase ? (HSIZE_I == ifpm_pkg::HSIZE_WORD) : word_q;
        // Read data formed at address phase; routing regs read as zero
        rdata_d = 32'h0000_0000; // R12
        if (addr_phase && !HWRITE_I && HADDR_I[7:0] == ifpm_pkg::OFS_STATUS) begin
            for (int f = 0; f < NF; f++) begin
                rdata_d[ifpm_pkg::STS_LEVEL_LSB + f] = func_q[f];
                rdata_d[ifpm_pkg::STS_ASSIGNED_LSB + f] = route_q[f].assigned;
            end
            rdata_d[ifpm_pkg::STS_REJECT] = reject_q;
        end
    end

    // Bus registers
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
            word_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= wr_pend_d;
            addr_q <= addr_d;
            word_q <= word_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write decode in the data phase; sub-word writes are ignored
    always_comb begin
        wr_ok = wr_pend_q & word_q;
        cmd_wr = wr_ok & (addr_q == ifpm_pkg::OFS_COMMAND);
        bad_value = HWDATA_I > ifpm_pkg::ROUTE_MAX;
        for (int f = 0; f < NF; f++) begin
            route_wr[f] = wr_ok & (addr_q == ifpm_pkg::OFS_ROUTE[f]);
            inv_wr[f] = wr_ok & (addr_q == ifpm_pkg::OFS_INV[f]);
        end
        // Start and alarm-clear pins act on their rising edge
        reinit = (cmd_wr & (HWDATA_I[ifpm_pkg::CMD_RUN] | HWDATA_I[ifpm_pkg::CMD_ALARM_CLEAR]))
               | (START_I & ~start_q)
               | (ALARM_CLR_I & ~alarm_q); // R7 R8
    end

    ////////////////////////////////////////////////////////////////////////////
    // Routing table next state; reinit outranks every write
    always_comb begin
        for (int f = 0; f < NF; f++) begin
            route_d[f] = route_q[f];
            if (route_wr[f] && !bad_value) begin
                route_d[f].assigned = 1'b1; // R2 R3 R11
                route_d[f].port = HWDATA_I[2:0]; // R4
            end
            // Invert may be set unrouted; software orders it after routing
            if (inv_wr[f]) begin
                route_d[f].invert = HWDATA_I[0]; // R5 R9 R10
            end
            if (cmd_wr && HWDATA_I[ifpm_pkg::CMD_CLEAR_ALL]) begin
                route_d[f].assigned = 1'b0; // R1
            end
            if (reinit) begin
                route_d[f] = ifpm_pkg::ROUTE_DEFAULT; // R6 R7 R8
            end
        end
        // Sticky reject; a new reject beats a clear in the same cycle
        reject_d = ((|route_wr) & bad_value)
                 | (reject_q & ~(cmd_wr & HWDATA_I[ifpm_pkg::CMD_REJECT_CLR])); // R12
        func_d = sel_level;
    end

    // Volatile routing flops; reset is the power-on default
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int f = 0; f < NF; f++) begin
                route_q[f] <= ifpm_pkg::ROUTE_DEFAULT; // R6 R7
            end
            reject_q <= 1'b0;
            func_q <= '0;
            start_q <= 1'b0;
            alarm_q <= 1'b0;
        end else begin
            for (int f = 0; f < NF; f++) begin
                route_q[f] <= route_d[f];
            end
            reject_q <= reject_d;
            func_q <= func_d;
            start_q <= START_I;
            alarm_q <= ALARM_CLR_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One selector per function
    generate
        for (genvar g = 0; g < NF; g++) begin : g_sel
            ifpm_selector u_sel (
                .gp_in_i(GP_IN_I),
                .route_i(route_q[g]),
                .level_o(sel_level[g])
            );
        end
    endgenerate

    // Outputs straight from flops; bus ready and response are tied constants
    always_comb begin
        HRDATA_O = rdata_q;
        HREADYOUT_O = 1'b1;
        HRESP_O = 1'b0;
        HALT_O = func_q[ifpm_pkg::FUNC_HALT];
        HOLD_O = func_q[ifpm_pkg::FUNC_HOLD];
        RESUME_O = func_q[ifpm_pkg::FUNC_RESUME];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    clear_all_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        cmd_wr && HWDATA_I[ifpm_pkg::CMD_CLEAR_ALL] |=>
            !route_q[0].assigned && !route_q[1].assigned && !route_q[2].assigned) // R1
        else $error("clear-all left a routing active");

    halt_route_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        route_wr[0] && !bad_value && !reinit && !cmd_wr |=>
            route_q[0].assigned && route_q[0].port == $past(HWDATA_I[2:0])) // R2
        else $error("halt routing not taken");

    hold_route_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        route_wr[1] && !bad_value && !reinit |=>
            route_q[1].assigned && route_q[1].port == $past(HWDATA_I[2:0])) // R3
        else $error("hold routing not taken");

    resume_route_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        route_wr[2] && !bad_value && !reinit |=>
            route_q[2].assigned && route_q[2].port == $past(HWDATA_I[2:0])) // R11
        else $error("resume routing not taken");

    halt_level_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        route_q[0].assigned |=> HALT_O ==
            ($past(GP_IN_I[route_q[0].port]) ^ $past(route_q[0].invert))) // R4 R5
        else $error("halt output does not follow routed port");

    reject_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        route_wr[1] && bad_value && !reinit |=>
            route_q[1] == $past(route_q[1]) && reject_q) // R12
        else $error("out of range routing not rejected");

    start_reinit_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        START_I && !start_q |=> route_q[0] == ifpm_pkg::ROUTE_DEFAULT
            && route_q[1] == ifpm_pkg::ROUTE_DEFAULT && route_q[2] == ifpm_pkg::ROUTE_DEFAULT) // R7
        else $error("program start did not restore defaults");

    alarm_reinit_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        ALARM_CLR_I && !alarm_q |=> route_q[1] == ifpm_pkg::ROUTE_DEFAULT ##1
            !route_q[1].assigned || $past(route_wr[1])) // R6 R8
        else $error("alarm clear did not restore defaults");

    route_read_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
        addr_phase && !HWRITE_I && HADDR_I[7:0] == ifpm_pkg::OFS_ROUTE[0] |=>
            HRDATA_O == 32'h0000_0000) // R12
        else $error("routing register readable");

    halt_cover_c: cover property (@(posedge CORE_CLK_I) disable iff (RST_I)
        route_wr[0] && !bad_value ##1 HALT_O);
    invert_cover_c: cover property (@(posedge CORE_CLK_I) disable iff (RST_I)
        route_q[1].assigned && route_q[1].invert && HOLD_O);
    reject_cover_c: cover property (@(posedge CORE_CLK_I) disable iff (RST_I)
        route_wr[2] && bad_value);
    reinit_cover_c: cover property (@(posedge CORE_CLK_I) disable iff (RST_I)
        route_q[0].assigned && reinit);

endmodule : ifpm_top
`default_nettype wire

// [tb_input_function_port_mapper.sv]
// Self-checking bench for the input function port mapper.
// Assumes the host model is sole bus master; switches are driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_input_function_port_mapper;
    logic clk, rst, start, alm_clr, hready, hresp, halt, hold, resume, hwrite;
    logic [7:0] gp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    // Select and size tied: one slave, word transfers only
    ifpm_top i_dut (.CORE_CLK_I(clk), .RST_I(rst), .HSEL_I(1'b1), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(ifpm_pkg::HSIZE_WORD),
        .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
        .HRESP_O(hresp), .GP_IN_I(gp), .START_I(start), .ALARM_CLR_I(alm_clr),
        .HALT_O(halt), .HOLD_O(hold), .RESUME_O(resume));
    ifpm_host_model i_host (.clk_i(clk), .hready_i(hready), .hrdata_i(hrdata),
        .htrans_o(htrans), .haddr_o(haddr), .hwrite_o(hwrite), .hwdata_o(hwdata));
    ////////////////////////////////////////////////////////////
    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] r;
        i_host.xfer(1'b1, adr, d, r);
    endtask : wr
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string msg);
        logic [31:0] r;
        i_host.xfer(1'b0, adr, 32'h0, r);
        chk(r, exp, msg);
    endtask : rd_chk
    // Samples before the edge's own updates land
    task automatic look(input int n);
        repeat (n) @(posedge clk);
    endtask : look
    function automatic logic fsel(input int f);
        return (f == 0) ? halt : ((f == 1) ? hold : resume);
    endfunction : fsel
    ////////////////////////////////////////////////////////////
    task automatic test_reset();
        look(1);
        chk({hresp, hready, resume, hold, halt}, 5'h08, "reset outputs");
        rd_chk(ifpm_pkg::OFS_STATUS, 32'h0, "status after reset");
        rd_chk(8'hfc, 32'h0, "unmapped read");
    endtask : test_reset
    // Every function to every port, both levels
    task automatic test_route();
        for (int f = 0; f < 3; f++) begin
            for (int p = 0; p < 8; p++) begin
                gp <= 8'h01 << p;
                i_host.set_route(f, p, 1'b0);
                look(3);
                chk(fsel(f), 1'b1, "routed port high");
                gp <= ~(8'h01 << p);
                look(3);
                chk(fsel(f), 1'b0, "routed port low");
            end
        end
        rd_chk(ifpm_pkg::OFS_ROUTE[0], 32'h0, "routing reads zero");
        rd_chk(ifpm_pkg::OFS_STATUS, 32'h70, "all assigned");
    endtask : test_route
    task automatic test_invert();
        gp <= 8'h00;
        i_host.set_route(1, 3, 1'b1);
        look(3);
        chk(hold, 1'b1, "inverted low input");
        gp <= 8'h08;
        look(3);
        chk(hold, 1'b0, "inverted high input");
    endtask : test_invert
    // Inputs all high so a surviving halt or resume routing would show
    task automatic test_clear_all();
        gp <= 8'hff;
        wr(ifpm_pkg::OFS_COMMAND, 32'h1 << ifpm_pkg::CMD_CLEAR_ALL);
        look(3);
        chk({resume, hold, halt}, 3'h0, "after clear all");
        rd_chk(ifpm_pkg::OFS_STATUS, 32'h0, "nothing assigned");
    endtask : test_clear_all
    // Run and alarm commands, then start and alarm pins
    task automatic test_restore();
        for (int s = 0; s < 4; s++) begin
            gp <= 8'h01;
            i_host.set_route(0, 0, 1'b1);
            i_host.set_route(2, 0, 1'b0);
            look(3);
            chk({resume, halt}, 2'b10, "before restore");
            if (s == 0) begin
                wr(ifpm_pkg::OFS_COMMAND, 32'h1 << ifpm_pkg::CMD_RUN);
            end else if (s == 1) begin
                wr(ifpm_pkg::OFS_COMMAND, 32'h1 << ifpm_pkg::CMD_ALARM_CLEAR);
            end else if (s == 2) begin
                start <= 1'b1;
            end else begin
                alm_clr <= 1'b1;
            end
            look(3);
            chk({resume, hold, halt}, 3'h0, "after restore");
            // Pin still high: a held level must not keep clearing
            wr(ifpm_pkg::OFS_ROUTE[0], 32'h0);
            look(3);
            chk(halt, 1'b1, "polarity back to default");
            start <= 1'b0;
            alm_clr <= 1'b0;
        end
    endtask : test_restore
    task automatic test_reject();
        gp <= 8'h20;
        i_host.set_route(0, 5, 1'b0);
        wr(ifpm_pkg::OFS_ROUTE[0], 32'h8);
        wr(ifpm_pkg::OFS_ROUTE[0], 32'h100);
        // Bad values on the other two routings must leave them unassigned
        wr(ifpm_pkg::OFS_ROUTE[1], 32'h8);
        wr(ifpm_pkg::OFS_ROUTE[2], 32'h9);
        look(3);
        chk(halt, 1'b1, "halt kept on port five");
        rd_chk(ifpm_pkg::OFS_STATUS, 32'h111, "reject flagged");
        wr(ifpm_pkg::OFS_COMMAND, 32'h1 << ifpm_pkg::CMD_REJECT_CLR);
        // Status is sampled at its address phase, so let the clear land first
        look(1);
        rd_chk(ifpm_pkg::OFS_STATUS, 32'h11, "reject cleared");
    endtask : test_reject
    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        gp = 8'h00;
        start = 1'b0;
        alm_clr = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_route();
        test_invert();
        test_clear_all();
        test_restore();
        test_reject();
        end_sim();
    end
endmodule : tb_input_function_port_mapper
`default_nettype wire
